// *** include/gpc_pkg.sv ***
// Package of offsets, field positions and reset values for the GPIO and pin-change block
package gpc_pkg;

	// Geometry
	localparam int NUM_PORTS  = 4;
	localparam int PORT_WIDTH = 8;
	localparam int NUM_PINS   = NUM_PORTS * PORT_WIDTH;

	// Per-port register offsets: base + 3 * port + slot
	localparam logic [7:0] PORT_BASE_OFFSET = 8'h20;
	localparam logic [7:0] PIN_SLOT         = 8'h00;
	localparam logic [7:0] DIR_SLOT         = 8'h01;
	localparam logic [7:0] OUT_SLOT         = 8'h02;
	localparam logic [7:0] PORT_STRIDE      = 8'h03;

	// Shared control and status offsets
	localparam logic [7:0] CPU_CONTROL_OFFSET   = 8'h35;
	localparam logic [7:0] CHANGE_FLAG_OFFSET   = 8'h3B;
	localparam logic [7:0] CHANGE_CTRL_OFFSET   = 8'h68;
	localparam logic [7:0] CHANGE_MASK0_OFFSET  = 8'h6B;
	localparam logic [7:0] CHANGE_MASK1_OFFSET  = 8'h6C;
	localparam logic [7:0] CHANGE_MASK2_OFFSET  = 8'h6D;
	localparam logic [7:0] CHANGE_MASK3_OFFSET  = 8'h73;

	// Field positions
	localparam int PULLUP_DISABLE_BIT = 4;

	// Reset values
	localparam logic [7:0] OUT_RESET   = 8'h00;
	localparam logic [7:0] DIR_RESET   = 8'h00;
	localparam logic [7:0] MASK_RESET  = 8'h00;
	localparam logic [7:0] CTRL_RESET  = 8'h00;
	localparam logic [3:0] FLAG_RESET  = 4'h0;
	localparam logic [7:0] READ_ZERO   = 8'h00;

endpackage : gpc_pkg

// *** logic/gpc_port.sv ***
// One 8-pin port: output, direction, toggle, input synchroniser and change detection
`timescale 1ns/1ps
module gpc_port
	import gpc_pkg::*;
(
	// Clock and reset
	input  wire logic                  clk,
	input  wire logic                  reset_n,
	// Pin side
	input  wire logic [PORT_WIDTH-1:0] pin_raw,
	input  wire logic                  sleep_clamp,
	input  wire logic                  pullup_disable,
	input  wire logic [PORT_WIDTH-1:0] alt_enable,
	input  wire logic [PORT_WIDTH-1:0] alt_oe,
	input  wire logic [PORT_WIDTH-1:0] alt_out,
	// Register writes, shared by all pins of the port
	input  wire logic [PORT_WIDTH-1:0] out_wmask,
	input  wire logic [PORT_WIDTH-1:0] out_wval,
	input  wire logic [PORT_WIDTH-1:0] dir_wmask,
	input  wire logic [PORT_WIDTH-1:0] dir_wval,
	input  wire logic [PORT_WIDTH-1:0] toggle,
	// Register state
	output logic      [PORT_WIDTH-1:0] output_value_reg,
	output logic      [PORT_WIDTH-1:0] direction_reg,
	output logic      [PORT_WIDTH-1:0] pin_input_reg,
	output logic      [PORT_WIDTH-1:0] changed,
	// Pin drive, registered
	output logic      [PORT_WIDTH-1:0] drv_oe,
	output logic      [PORT_WIDTH-1:0] drv_out,
	output logic      [PORT_WIDTH-1:0] drv_pullup
);

	logic [PORT_WIDTH-1:0] sync1;
	logic [PORT_WIDTH-1:0] sync2;
	logic [PORT_WIDTH-1:0] sync3;
	logic [PORT_WIDTH-1:0] prev_pin;

	// Masked writes touch only the selected bits; toggle wins after the write
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			output_value_reg <= OUT_RESET;
		end else begin
			output_value_reg <= ((output_value_reg & ~out_wmask) | (out_wval & out_wmask)) ^ toggle;
		end
	end

	// Direction register, bitwise update
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			direction_reg <= DIR_RESET;
		end else begin
			direction_reg <= (direction_reg & ~dir_wmask) | (dir_wval & dir_wmask);
		end
	end

	// Input synchroniser; clamp grounds floating inputs in deep sleep
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			sync1 <= READ_ZERO;
			sync2 <= READ_ZERO;
			sync3 <= READ_ZERO;
		end else begin
			sync1 <= sleep_clamp ? READ_ZERO : pin_raw;
			sync2 <= sync1;
			sync3 <= sync2;
		end
	end

	// Pin value taken only when stages two and three agree, filtering a single glitch
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			pin_input_reg <= READ_ZERO;
			prev_pin      <= READ_ZERO;
		end else begin
			pin_input_reg <= (pin_input_reg & (sync2 ^ sync3)) | (sync3 & ~(sync2 ^ sync3));
			prev_pin      <= pin_input_reg;
		end
	end

	// Difference against previous cycle marks a level change
	assign changed = pin_input_reg ^ prev_pin;

	// Drive state: alternate function takes only its own pins
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			drv_oe     <= READ_ZERO;
			drv_out    <= READ_ZERO;
			drv_pullup <= READ_ZERO;
		end else begin
			drv_oe     <= (alt_enable & alt_oe) | (~alt_enable & direction_reg);
			drv_out    <= (alt_enable & alt_out) | (~alt_enable & output_value_reg);
			drv_pullup <= ~alt_enable & ~direction_reg & output_value_reg
				& {PORT_WIDTH{~pullup_disable}};
		end
	end

endmodule : gpc_port

// *** logic/gpc_top.sv ***
// Top of the GPIO block: four ports, register access and pin-change interrupt groups
//
// Overview of operation
// - Masked pin change sets its group flag
// - Flag clears on vector entry or one-write
// - Request when flag, global and group enable
// - Eight-bit mask per group, bit per pin
// - Mask zero ignores that pin's changes
// - Bitwise set and clear touch one pin
// - Output, direction read/write; pin input read-only
// - One written to input register toggles output
// - Global pull-up disable kills every pull-up
// - Direction one is output, zero input
// - Input with output bit one pulls up
// - Reset tri-states pins without any clock
// - Output pin follows output value bit
// - Alternate function leaves other pins usable
// - Strobes per port; clock, clamp, pull-up shared
// - Each pin has its own pull-up
// - Mask registers reset to zero, read/write
// - Pin level reaches input register after synchronising
// - Any enabled-pin change raises group interrupt
`timescale 1ns/1ps
module gpc_top
	import gpc_pkg::*;
(
	// Clock and reset
	input  wire logic                  clk,
	input  wire logic                  reset_n,
	// CPU I/O access
	input  wire logic [7:0]            io_addr,
	input  wire logic [7:0]            io_wdata,
	input  wire logic                  io_write,
	input  wire logic                  io_read,
	input  wire logic                  io_bit_op,
	input  wire logic [2:0]            io_bit_num,
	output logic      [7:0]            io_rdata,
	// Interrupt handshake with the core
	input  wire logic                  global_irq_enable,
	input  wire logic [NUM_PORTS-1:0]  irq_enter,
	output logic      [NUM_PORTS-1:0]  irq_request,
	// Shared sleep clamp and alternate functions
	input  wire logic                  sleep_clamp,
	input  wire logic [NUM_PINS-1:0]   alt_enable,
	input  wire logic [NUM_PINS-1:0]   alt_oe,
	input  wire logic [NUM_PINS-1:0]   alt_out,
	// Pins
	input  wire logic [NUM_PINS-1:0]   pin_in,
	output logic      [NUM_PINS-1:0]   pin_out,
	output logic      [NUM_PINS-1:0]   pin_oe,
	output logic      [NUM_PINS-1:0]   pin_pullup
);

	logic [7:0]                 cpu_control_reg;
	logic [7:0]                 change_interrupt_control;
	logic [NUM_PORTS-1:0]       change_flags;
	logic [7:0]                 change_mask [NUM_PORTS];
	logic [7:0]                 next_rdata;
	logic [7:0]                 wr_mask;
	logic [7:0]                 wr_val;
	logic [NUM_PORTS-1:0]       flag_set;
	logic [NUM_PORTS-1:0]       flag_clear;
	logic [NUM_PINS-1:0]        drv_oe;
	logic [NUM_PINS-1:0]        drv_out;
	logic [NUM_PINS-1:0]        drv_pullup;
	logic [PORT_WIDTH-1:0]      out_q   [NUM_PORTS];
	logic [PORT_WIDTH-1:0]      dir_q   [NUM_PORTS];
	logic [PORT_WIDTH-1:0]      pin_q   [NUM_PORTS];
	logic [PORT_WIDTH-1:0]      changed [NUM_PORTS];
	logic                       pullup_disable;

	// Bit operations become a one-bit mask, byte writes a full mask
	always_comb begin
		wr_mask = io_bit_op ? (8'h01 << io_bit_num) : 8'hFF;
		wr_val  = io_bit_op ? {8{io_wdata[0]}} : io_wdata;
	end

	assign pullup_disable = cpu_control_reg[PULLUP_DISABLE_BIT];

	// Four identical ports; strobes decoded per port, clock and pull-up disable shared
	for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
		localparam logic [7:0] BASE = PORT_BASE_OFFSET + PORT_STRIDE * 8'(p);
		logic hit_pin;
		logic hit_dir;
		logic hit_out;

		assign hit_pin = io_write && (io_addr == BASE + PIN_SLOT);
		assign hit_dir = io_write && (io_addr == BASE + DIR_SLOT);
		assign hit_out = io_write && (io_addr == BASE + OUT_SLOT);

		gpc_port u_port (
			.clk              (clk),
			.reset_n          (reset_n),
			.pin_raw          (pin_in[p*PORT_WIDTH +: PORT_WIDTH]),
			.sleep_clamp      (sleep_clamp),
			.pullup_disable   (pullup_disable),
			.alt_enable       (alt_enable[p*PORT_WIDTH +: PORT_WIDTH]),
			.alt_oe           (alt_oe[p*PORT_WIDTH +: PORT_WIDTH]),
			.alt_out          (alt_out[p*PORT_WIDTH +: PORT_WIDTH]),
			.out_wmask        (hit_out ? wr_mask : 8'h00),
			.out_wval         (wr_val),
			.dir_wmask        (hit_dir ? wr_mask : 8'h00),
			.dir_wval         (wr_val),
			.toggle           (hit_pin ? (wr_mask & wr_val) : 8'h00),
			.output_value_reg (out_q[p]),
			.direction_reg    (dir_q[p]),
			.pin_input_reg    (pin_q[p]),
			.changed          (changed[p]),
			.drv_oe           (drv_oe[p*PORT_WIDTH +: PORT_WIDTH]),
			.drv_out          (drv_out[p*PORT_WIDTH +: PORT_WIDTH]),
			.drv_pullup       (drv_pullup[p*PORT_WIDTH +: PORT_WIDTH])
		);

		// Any masked change sets the flag; unmasked pins are ignored
		assign flag_set[p] = |(changed[p] & change_mask[p]);
		// Vector entry or a one written to the flag bit clears it
		assign flag_clear[p] = irq_enter[p]
			|| (io_write && io_addr == CHANGE_FLAG_OFFSET && wr_mask[p] && wr_val[p]);
	end

	// Reset overrides the drive asynchronously so pins float even with the clock stopped
	assign pin_oe     = drv_oe & {NUM_PINS{reset_n}};
	assign pin_pullup = drv_pullup & {NUM_PINS{reset_n}};
	assign pin_out    = drv_out;

	// Control register holding the shared pull-up disable
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			cpu_control_reg <= CTRL_RESET;
		end else if (io_write && io_addr == CPU_CONTROL_OFFSET) begin
			cpu_control_reg <= (cpu_control_reg & ~wr_mask) | (wr_val & wr_mask);
		end
	end

	// Group enables
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			change_interrupt_control <= CTRL_RESET;
		end else if (io_write && io_addr == CHANGE_CTRL_OFFSET) begin
			change_interrupt_control <= (change_interrupt_control & ~wr_mask) | (wr_val & wr_mask);
		end
	end

	// Mask registers, one per group
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			for (int g = 0; g < NUM_PORTS; g++) begin
				change_mask[g] <= MASK_RESET;
			end
		end else if (io_write) begin
			unique case (io_addr)
				CHANGE_MASK0_OFFSET: change_mask[0] <= (change_mask[0] & ~wr_mask) | (wr_val & wr_mask);
				CHANGE_MASK1_OFFSET: change_mask[1] <= (change_mask[1] & ~wr_mask) | (wr_val & wr_mask);
				CHANGE_MASK2_OFFSET: change_mask[2] <= (change_mask[2] & ~wr_mask) | (wr_val & wr_mask);
				CHANGE_MASK3_OFFSET: change_mask[3] <= (change_mask[3] & ~wr_mask) | (wr_val & wr_mask);
				default: ;
			endcase
		end
	end

	// Sticky flags: a change in the clearing cycle is kept, so set wins
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			change_flags <= FLAG_RESET;
		end else begin
			change_flags <= (change_flags & ~flag_clear) | flag_set;
		end
	end

	// Request needs flag, group enable and the global enable
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			irq_request <= FLAG_RESET;
		end else begin
			irq_request <= change_flags & change_interrupt_control[NUM_PORTS-1:0]
				& {NUM_PORTS{global_irq_enable}};
		end
	end

	// Read mux; unmapped addresses answer zero
	always_comb begin
		next_rdata = READ_ZERO;
		for (int p = 0; p < NUM_PORTS; p++) begin
			if (io_addr == PORT_BASE_OFFSET + PORT_STRIDE * 8'(p) + PIN_SLOT) next_rdata = pin_q[p];
			if (io_addr == PORT_BASE_OFFSET + PORT_STRIDE * 8'(p) + DIR_SLOT) next_rdata = dir_q[p];
			if (io_addr == PORT_BASE_OFFSET + PORT_STRIDE * 8'(p) + OUT_SLOT) next_rdata = out_q[p];
		end
		if (io_addr == CPU_CONTROL_OFFSET)  next_rdata = cpu_control_reg;
		if (io_addr == CHANGE_CTRL_OFFSET)  next_rdata = change_interrupt_control;
		if (io_addr == CHANGE_FLAG_OFFSET)  next_rdata = {4'h0, change_flags};
		if (io_addr == CHANGE_MASK0_OFFSET) next_rdata = change_mask[0];
		if (io_addr == CHANGE_MASK1_OFFSET) next_rdata = change_mask[1];
		if (io_addr == CHANGE_MASK2_OFFSET) next_rdata = change_mask[2];
		if (io_addr == CHANGE_MASK3_OFFSET) next_rdata = change_mask[3];
	end

	// Read data registered; holds its value between reads
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			io_rdata <= READ_ZERO;
		end else if (io_read) begin
			io_rdata <= next_rdata;
		end
	end

endmodule : gpc_top

// *** tb/gpc_chk.sv ***
// Checker of the block top: pin drive, register access and pin-change requests
`timescale 1ns/1ps
module gpc_chk
	import gpc_pkg::*;
(
	// Clock and reset
	input wire logic                 clk,
	input wire logic                 reset_n,
	// Register access
	input wire logic                 io_write,
	input wire logic                 io_read,
	input wire logic                 io_bit_op,
	input wire logic [7:0]           io_addr,
	input wire logic [7:0]           io_wdata,
	input wire logic [7:0]           io_rdata,
	// Interrupts
	input wire logic                 global_irq_enable,
	input wire logic [NUM_PORTS-1:0] irq_enter,
	input wire logic [NUM_PORTS-1:0] irq_request,
	// Pins
	input wire logic [NUM_PINS-1:0]  pin_in,
	input wire logic [NUM_PINS-1:0]  pin_out,
	input wire logic [NUM_PINS-1:0]  pin_oe,
	input wire logic [NUM_PINS-1:0]  pin_pullup
);
	logic [7:0] prev_pins;
	logic [3:0] calm;
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	// Edges the top port's pins have held still; saturates so it never wraps
	always_ff @(posedge clk) begin
		prev_pins <= pin_in[31:24];
		if (!reset_n || pin_in[31:24] != prev_pins)
			calm <= 4'h0;
		else if (calm != 4'hF)
			calm <= calm + 4'h1;
	end
	// A plain byte write followed by a quiet cycle
	sequence s_wr(logic [7:0] a);
		io_write && !io_bit_op && io_addr == a ##1 !io_write;
	endsequence
	// Reset must be checked while it is active, so this one is never disabled
	AST_RESET_TRISTATE: assert property (disable iff (1'b0) !reset_n |-> pin_oe == '0 && pin_pullup == '0)
		else $error("pins driven during reset");
	AST_DIR_DRIVES_OE: assert property (s_wr(8'h2A) |=> pin_oe[31:24] == $past(io_wdata, 2))
		else $error("pin enable does not follow direction");
	AST_OUT_DRIVES_PIN: assert property (s_wr(8'h2B) |=> (pin_out[31:24] & pin_oe[31:24]) == ($past(io_wdata, 2) & pin_oe[31:24]))
		else $error("driven level does not follow output value");
	AST_TOGGLE: assert property (!io_write ##1 !io_write ##1 pin_oe[31:24] == 8'hFF ##0 s_wr(8'h29)
		|=> pin_out[31:24] == ($past(pin_out[31:24], 2) ^ $past(io_wdata, 2)))
		else $error("write to pin register did not invert output");
	AST_PULLUP_OFF_ON_OUTPUT: assert property ((pin_pullup & pin_oe) == '0)
		else $error("pull-up on a driven pin");
	AST_PULLUP_DISABLE: assert property (io_wdata[PULLUP_DISABLE_BIT] ##0 s_wr(CPU_CONTROL_OFFSET) |=> pin_pullup == '0)
		else $error("pull-up survives global disable");
	AST_GLOBAL_GATE: assert property (irq_request != '0 |-> $past(global_irq_enable))
		else $error("request without global enable");
	AST_ENTER_CLEARS: assert property (irq_enter[3] && calm > 4'h8 |=> ##1 !irq_request[3])
		else $error("vector entry did not clear request");
	AST_PIN_READ: assert property (io_read && io_addr == 8'h29 && calm > 4'h8 |=> io_rdata == $past(pin_in[31:24]))
		else $error("pin register does not show settled pins");
	AST_MASK_RW: assert property (s_wr(CHANGE_MASK3_OFFSET) ##0 io_read && io_addr == CHANGE_MASK3_OFFSET
		|=> io_rdata == $past(io_wdata, 2))
		else $error("mask register read-back differs");
endmodule : gpc_chk

bind gpc_top gpc_chk u_chk (.clk, .reset_n, .io_write, .io_read, .io_bit_op, .global_irq_enable, .io_addr,
	.io_wdata, .io_rdata, .irq_enter, .irq_request, .pin_in, .pin_out, .pin_oe, .pin_pullup);

// *** tb/gpc_board.sv ***
// Board-side model of the pins: device drive, external sources, pull-ups and floating lines
`timescale 1ns/1ps
module gpc_board
	import gpc_pkg::*;
(
	// Clock
	input wire logic                clk,
	// Device drive
	input wire logic [NUM_PINS-1:0] pin_out,
	input wire logic [NUM_PINS-1:0] pin_oe,
	input wire logic [NUM_PINS-1:0] pin_pullup,
	// External sources
	input wire logic [NUM_PINS-1:0] ext_en,
	input wire logic [NUM_PINS-1:0] ext_val,
	// Levels seen by the device
	output logic     [NUM_PINS-1:0] pin_in
);
	logic float_q = 1'b0;
	// A floating line flips every cycle so a stale level never passes for a real one
	always @(posedge clk) begin
		float_q <= ~float_q;
	end
	// The device's own driver wins over an external source
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val) | (~pin_oe & ~ext_en & (pin_pullup | {NUM_PINS{float_q}}));
endmodule : gpc_board

// *** tb/tb_top.sv ***
// Self-checking bench of the GPIO ports and pin-change groups
`timescale 1ns/1ps
module tb_top;
	import gpc_pkg::*;
	logic        clk = 1'b0, reset_n = 1'b0, io_write = 1'b0, io_read = 1'b0, io_bit_op = 1'b0;
	logic        global_irq_enable = 1'b0;
	logic [2:0]  io_bit_num = 3'h0, b;
	logic [7:0]  io_addr = 8'h00, io_wdata = 8'h00, io_rdata, v, t, m;
	logic [3:0]  irq_enter = 4'h0, irq_request;
	logic [31:0] alt_enable = '0, alt_oe = '0, alt_out = '0, ext_val = '0, pin_in, pin_out, pin_oe, pin_pullup;
	logic [7:0]  maddr [4] = '{8'h6B, 8'h6C, 8'h6D, 8'h73};
	int          mismatches = 0, check_count = 0;
	// Block with the board model on its pins; sleep clamp held off
	gpc_top uut (.clk, .reset_n, .io_addr, .io_wdata, .io_write, .io_read, .io_bit_op, .io_bit_num, .io_rdata,
		.global_irq_enable, .irq_enter, .irq_request, .sleep_clamp(1'b0), .alt_enable, .alt_oe, .alt_out,
		.pin_in, .pin_out, .pin_oe, .pin_pullup);
	gpc_board board (.clk, .pin_out, .pin_oe, .pin_pullup, .ext_en({NUM_PINS{1'b1}}), .ext_val, .pin_in);
	// 4 ns clock
	initial begin
		forever #2 clk = ~clk;
	end
	// Hang guard
	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		print_verdict();
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic idle(input int n);
		repeat (n) @(negedge clk);
	endtask : idle
	// Leading wait keeps two writes from touching the strobe in one time step
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic bop = 1'b0, input logic [2:0] bn = 3'h0);
		@(negedge clk);
		io_addr = a;
		io_wdata = d;
		io_bit_op = bop;
		io_bit_num = bn;
		io_write = 1'b1;
		@(negedge clk);
		io_write = 1'b0;
		io_bit_op = 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
		io_addr = a;
		io_read = 1'b1;
		@(negedge clk);
		io_read = 1'b0;
		@(negedge clk);
		chk(io_rdata, exp, what);
	endtask : rd
	task automatic wait_irq(input int g, input logic val);
		for (int i = 0; i < 12 && irq_request[g] !== val; i++)
			@(negedge clk);
		chk(irq_request[g], val, "irq_request");
		if (irq_request[g] !== val)
			print_verdict();
	endtask : wait_irq
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : print_verdict
	// Main sequence
	initial begin
		void'($urandom(32'h78fcb250));
		ext_val = $urandom;
		repeat (4) @(negedge clk);
		chk(pin_oe | pin_pullup, 32'h0, "pins in reset");
		reset_n = 1'b1;
		for (int p = 0; p < 4; p++) begin
			v = 8'($urandom);
			rd(8'(8'h21 + 3 * p), DIR_RESET, "dir reset");
			rd(maddr[p], MASK_RESET, "mask reset");
			wr(maddr[p], v);
			rd(maddr[p], v, "mask rw");
		end
		rd(8'h00, READ_ZERO, "unmapped");
		// Top port as outputs, then toggled through its read-only pin register
		v = 8'($urandom);
		t = 8'($urandom);
		wr(8'h2A, 8'hFF);
		wr(8'h2B, v);
		idle(3);
		chk({pin_oe[31:24], pin_out[31:24]}, {8'hFF, v}, "drive");
		idle(2);
		wr(8'h29, t);
		rd(8'h2B, v ^ t, "toggle");
		idle(10);
		rd(8'h29, v ^ t, "pin level");
		// Single-bit operations and an alternate function on port 0
		b = 3'($urandom);
		wr(8'h21, v);
		wr(8'h21, 8'h01, 1'b1, b);
		rd(8'h21, v | (8'h01 << b), "bit set");
		wr(8'h21, 8'h00, 1'b1, b);
		rd(8'h21, v & ~(8'h01 << b), "bit clear");
		wr(8'h22, v);
		wr(8'h20, 8'h01, 1'b1, b);
		t = v ^ (8'h01 << b);
		rd(8'h22, t, "bit toggle");
		alt_enable[0] = 1'b1;
		alt_oe[0] = 1'b1;
		alt_out[0] = 1'b1;
		wr(8'h21, 8'hFE);
		idle(3);
		chk({pin_oe[7:0], pin_out[7:0]}, {8'hFF, t[7:1], 1'b1}, "alt pin");
		alt_enable[0] = 1'b0;
		// Pull-ups on port 1
		wr(8'h25, 8'hA5);
		idle(3);
		chk(pin_pullup[15:8], 8'hA5, "pull-up");
		wr(CPU_CONTROL_OFFSET, 8'h10);
		idle(3);
		chk(pin_pullup, 32'h0, "pull-up off");
		wr(CPU_CONTROL_OFFSET, 8'h00);
		wr(8'h24, 8'h0F);
		idle(3);
		chk(pin_pullup[15:8], 8'hA0, "pull-up per pin");
		// Per group: unmasked pin ignored, masked pin flags, global gate, clearing by vector entry on odd groups and by flag write on even
		global_irq_enable = 1'b1;
		for (int g = 0; g < 4; g++) begin
			b = 3'($urandom);
			m = (8'($urandom) | (8'h01 << b)) & ~(8'h01 << (b ^ 3'h4));
			wr(8'(8'h21 + 3 * g), 8'h00);
			wr(maddr[g], m);
			wr(CHANGE_CTRL_OFFSET, 8'h01 << g);
			idle(8);
			wr(CHANGE_FLAG_OFFSET, 8'h0F);
			ext_val[8 * g + (b ^ 3'h4)] ^= 1'b1;
			idle(8);
			chk(irq_request, 4'h0, "masked off");
			ext_val[8 * g + b] ^= 1'b1;
			wait_irq(g, 1'b1);
			rd(CHANGE_FLAG_OFFSET, 8'h01 << g, "flag");
			global_irq_enable = 1'b0;
			idle(2);
			chk(irq_request, 4'h0, "global gate");
			global_irq_enable = 1'b1;
			// Group enable off keeps the flag but silences the request
			wr(CHANGE_CTRL_OFFSET, 8'h00);
			idle(2);
			chk(irq_request, 4'h0, "group gate");
			wr(CHANGE_CTRL_OFFSET, 8'h01 << g);
			wait_irq(g, 1'b1);
			idle(4);
			if (g % 2) begin
				irq_enter[g] = 1'b1;
				idle(1);
				irq_enter[g] = 1'b0;
			end else
				wr(CHANGE_FLAG_OFFSET, 8'h01 << g);
			wait_irq(g, 1'b0);
		end
		// Mid-run reset with port 3 driving and port 1 pulled up; pins must float before any clock edge
		wr(8'h2A, 8'hFF);
		idle(3);
		chk({pin_oe[31:24], pin_pullup[15:8]}, {8'hFF, 8'hA5}, "drive before reset");
		reset_n = 1'b0;
		#1;
		chk(pin_oe | pin_pullup, 32'h0, "pins float in reset");
		idle(2);
		reset_n = 1'b1;
		rd(8'h2A, DIR_RESET, "dir after reset");
		rd(maddr[3], MASK_RESET, "mask after reset");
		print_verdict();
	end
endmodule : tb_top
